// ---- core/spmc_pkg.sv ----
// Constants, register map and state encoding for the switch power mode control block
package spmc_pkg;
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] REG_POWER_MODE   = 8'h0E;
  localparam logic [7:0] REG_IDLE_TIMEOUT = 8'h0F;
  localparam logic [7:0] REG_PORT_CTRL    = 8'h1D;
  localparam logic [7:0] PORT_STRIDE      = 8'h10;
  localparam logic [7:0] REG_EEE_CTRL     = 8'h50;
  localparam logic [7:0] REG_STATUS       = 8'h60;
  localparam logic [7:0] REG_FREE_LO      = 8'h61;
  localparam logic [7:0] REG_FREE_HI      = 8'h62;
  localparam logic [7:0] REG_PHY_CTRL_HI  = 8'h90;

  // Field positions
  localparam int MODE_LSB   = 3;
  localparam int MODE_MSB   = 4;
  localparam int PORT_PD    = 3;
  localparam int PHY_PD     = 3;
  localparam int EEE_LPI    = 0;
  localparam int ST_AWAKE   = 0;
  localparam int ST_TXLPI   = 1;
  localparam int ST_RXLPI   = 2;
  localparam int ST_TXALLOW = 3;
  localparam int ST_ENERGY  = 4;

  // Mode codes
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_ENERGY  = 2'h1;
  localparam logic [1:0] MODE_SOFT_PD = 2'h2;
  localparam logic [1:0] MODE_RSVD    = 2'h3;

  // Reset values
  localparam logic [1:0] POWER_MODE_RST   = 2'h0;
  localparam logic [7:0] IDLE_TIMEOUT_RST = 8'h10;

  // Sizes
  localparam int NPORT     = 3;
  localparam int NBUF      = 512;
  localparam int BUF_BYTES = 128;

  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PULSE_WIDTH_NS  = 120;
  localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_NS = 1_000_000_000;
  localparam int PULSE_PERIOD_CYC = (PULSE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_TICK_NS   = 1_000_000;
  localparam int SLEEP_TICK_CYC  = (SLEEP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LPI_WAKE_NS     = 30_000;
  localparam int LPI_WAKE_CYC    = (LPI_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power states, one-hot
  typedef enum logic [3:0] {
    ST_NORMAL   = 4'h1,
    ST_ED_AWAKE = 4'h2,
    ST_ED_SLEEP = 4'h4,
    ST_SOFT_PD  = 4'h8
  } spmc_state_t;
endpackage

// ---- core/spmc_tick_div.sv ----
// Clock divider giving a one-cycle enable pulse every DIV cycles
`timescale 1ns/1ns
module spmc_tick_div #(
  parameter int DIV = 100
) (
  input  wire logic clk,   // System clock
  input  wire logic nrst,  // Async reset, active low
  input  wire logic clr,   // Restart the count
  output logic      tick   // One-cycle enable
);
  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  if (DIV < 2) $error("spmc_tick_div: DIV must be at least 2");

  logic [CW-1:0] cnt;
  wire           atLast = (cnt == LAST);

  // Free-running count, restarted by clr
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (clr) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= atLast ? '0 : cnt + 1'b1;
      tick <= atLast;
    end
  end
endmodule

// ---- core/spmc_buf_pool.sv ----
// Free-buffer pool accounting for the shared store-and-forward frame memory
`timescale 1ns/1ns
module spmc_buf_pool #(
  parameter int NBUF = 512
) (
  input  wire logic                    clk,        // System clock
  input  wire logic                    nrst,       // Async reset, active low
  input  wire logic                    clr,        // Internal reset, refills pool
  input  wire logic                    allocReq,   // Request one buffer
  input  wire logic                    freeReq,    // Return one buffer
  output logic                         allocGrant, // Buffer granted
  output logic [$clog2(NBUF+1)-1:0]    freeCount   // Buffers left
);
  localparam int CW = $clog2(NBUF + 1);
  localparam logic [CW-1:0] FULL = CW'(NBUF);

  if (NBUF < 2) $error("spmc_buf_pool: NBUF must be at least 2");

  wire canAlloc = allocReq && (freeCount != '0);
  wire canFree  = freeReq && (freeCount != FULL);
  wire [CW-1:0] next_freeCount = (canAlloc && !canFree) ? freeCount - 1'b1 :
                                 (canFree && !canAlloc) ? freeCount + 1'b1 : freeCount;

  // Grant never exceeds the pool; an accepted free beside a granted alloc keeps the count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      freeCount  <= FULL;
      allocGrant <= 1'b0;
    end else if (clr) begin
      freeCount  <= FULL;
      allocGrant <= 1'b0;
    end else begin
      freeCount  <= next_freeCount;
      allocGrant <= canAlloc;
    end
  end

  chk_grant_pool: assert property (@(posedge clk) disable iff (!nrst)
    allocGrant |-> $past(freeCount) != '0 && freeCount == $past(freeCount) - 1'b1
      || $past(freeReq))
    else $error("buffer granted from empty pool");
endmodule

// ---- core/spmc_power_ctrl.sv ----
// Power mode control: modes, energy detect sleep, soft power-down, port power-down, LPI
`timescale 1ns/1ns
// How it works
// - Mode field codes: 00 normal, 01 energy detect, 10 soft power-down, 11 reserved.
// - Reset leaves the mode field at normal operation.
// - Normal mode keeps clocks, PHYs, MACs and host interface all enabled.
// - Energy detect sleeps after no cable energy for longer than the idle timeout.
// - Sleeping disables everything except the receive energy detector.
// - Sleeping watches cable energy and wakes to normal power when it appears.
// - Sleeping emits a 120 ns pulse once every second.
// - Soft power-down stops all clocks and switches off every PHY and MAC.
// - Any host access wakes soft power-down and resets all registers to defaults.
// - Port control bit 3 powers down that PHY port.
// - PHY basic control bit 11 also powers down that PHY port.
// - Transmit and receive low-power idle are handled independently.
// - During low-power idle unused MAC and switch clocks are gated.
// - LPI entry waits for a frame boundary so no frame is cut.
// - Frame memory is 512 shared buffers of 128 bytes, store and forward.
// - LPI request sends assert-LPI, blocks transmit, resumes after a wake delay.
module spmc_power_ctrl #(
  parameter int NPORT            = spmc_pkg::NPORT,
  parameter int NBUF             = spmc_pkg::NBUF,
  parameter int SLEEP_TICK_CYC   = spmc_pkg::SLEEP_TICK_CYC,
  parameter int PULSE_PERIOD_CYC = spmc_pkg::PULSE_PERIOD_CYC
) (
  input  wire logic             clk,            // 100 MHz clock
  input  wire logic             nrst,           // Async reset, active low
  input  wire logic [7:0]       addr,           // Register address
  input  wire logic [7:0]       wrData,         // Write data
  input  wire logic             wrStb,          // Write strobe
  input  wire logic             rdStb,          // Read strobe
  output logic      [7:0]       rdData,         // Read data, cycle after rdStb
  input  wire logic             cableEnergy,    // Receiver sees cable energy
  input  wire logic             macTxBusy,      // MAC mid-frame on transmit
  input  wire logic             rxLpiInd,       // Partner signals LPI on receive
  input  wire logic             bufAllocReq,    // Frame buffer request
  input  wire logic             bufFreeReq,     // Frame buffer release
  output logic                  bufAllocGrant,  // Frame buffer granted
  output logic                  pllClkEn,       // PLL clocks run
  output logic                  macEn,          // MACs powered
  output logic                  hostIfEn,       // Host interface live
  output logic                  phyRxEnergyOnly,// PHY keeps only energy detector
  output logic [NPORT-1:0]      phyPowerDown,   // Per-port PHY off
  output logic                  edLowPower,     // Energy detect sleep state
  output logic                  linkPulse,      // Sleep keep-alive pulse
  output logic                  txLpiAssert,    // Send assert-LPI encoding
  output logic                  macTxAllow,     // MAC may transmit
  output logic                  macTxClkEn,     // MAC transmit clock enable
  output logic                  macRxClkEn,     // MAC receive clock enable
  output logic                  switchClkEn,    // Switch core clock enable
  output logic                  internalReset   // Pulse after soft power-down wake
);
  localparam int PW_CYC = spmc_pkg::PULSE_WIDTH_CYC;
  localparam int WK_CYC = spmc_pkg::LPI_WAKE_CYC;
  localparam int WKW    = $clog2(WK_CYC + 1);
  localparam int FCW    = $clog2(NBUF + 1);
  if (NPORT < 1 || NPORT > 8) $error("spmc_power_ctrl: NPORT out of range");
  if (PW_CYC < 1 || PW_CYC > 15) $error("spmc_power_ctrl: pulse width out of range");
  if (FCW > 16) $error("spmc_power_ctrl: NBUF too large for status");
  // Address match for a per-port register
  function automatic logic portHit(input logic [7:0] a, input logic [7:0] base, input int p);
    portHit = (a == 8'(base + 8'(p) * spmc_pkg::PORT_STRIDE));
  endfunction
  spmc_pkg::spmc_state_t state;
  spmc_pkg::spmc_state_t next_state;
  logic [1:0]       powerMode;
  logic [7:0]       idleTimeout;
  logic [NPORT-1:0] portPd;
  logic [NPORT-1:0] phyPd;
  logic             lpiReq;
  logic [8:0]       idleCnt;
  logic [3:0]       pulseCnt;
  logic [3:0]       pulseRun;
  logic [WKW-1:0]   wakeCnt;
  logic             lpiActive;
  logic             sleepTick;
  logic             periodTick;
  logic [FCW-1:0]   freeCount;

  // Host access gating: dead while asleep, a wake event in soft power-down
  wire hostOpen  = (state == spmc_pkg::ST_NORMAL) || (state == spmc_pkg::ST_ED_AWAKE);
  wire wrEn      = wrStb && hostOpen;
  wire rdEn      = rdStb && hostOpen;
  wire pdWake    = (state == spmc_pkg::ST_SOFT_PD) && (wrStb || rdStb);
  wire modeHit   = (addr == spmc_pkg::REG_POWER_MODE);
  wire [1:0] wrMode = wrData[spmc_pkg::MODE_MSB:spmc_pkg::MODE_LSB];
  wire modeWr    = wrEn && modeHit && (wrMode != spmc_pkg::MODE_RSVD);
  wire inEdAwake = (state == spmc_pkg::ST_ED_AWAKE);
  wire inSleep   = (state == spmc_pkg::ST_ED_SLEEP);
  wire sleepExpire = (idleCnt > {1'b0, idleTimeout});

  // Power state transitions
  always_comb begin
    next_state = state;
    case (state)
      spmc_pkg::ST_NORMAL: begin
        if (powerMode == spmc_pkg::MODE_ENERGY) next_state = spmc_pkg::ST_ED_AWAKE;
        else if (powerMode == spmc_pkg::MODE_SOFT_PD) next_state = spmc_pkg::ST_SOFT_PD;
      end
      spmc_pkg::ST_ED_AWAKE: begin
        if (powerMode != spmc_pkg::MODE_ENERGY) next_state = spmc_pkg::ST_NORMAL;
        else if (sleepExpire && !cableEnergy) next_state = spmc_pkg::ST_ED_SLEEP;
      end
      spmc_pkg::ST_ED_SLEEP: begin
        if (cableEnergy) next_state = spmc_pkg::ST_ED_AWAKE;
      end
      spmc_pkg::ST_SOFT_PD: begin
        if (wrStb || rdStb) next_state = spmc_pkg::ST_NORMAL;
      end
      default: next_state = spmc_pkg::ST_NORMAL;
    endcase
  end

  // Power gates per mode, registered from the next state to stay in step with it
  wire nxRun   = (next_state == spmc_pkg::ST_NORMAL) || (next_state == spmc_pkg::ST_ED_AWAKE);
  wire nxSleep = (next_state == spmc_pkg::ST_ED_SLEEP);
  wire nxPd    = (next_state == spmc_pkg::ST_SOFT_PD);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state           <= spmc_pkg::ST_NORMAL;
      pllClkEn        <= 1'b1;
      macEn           <= 1'b1;
      hostIfEn        <= 1'b1;
      phyRxEnergyOnly <= 1'b0;
      edLowPower      <= 1'b0;
      internalReset   <= 1'b0;
    end else begin
      state           <= next_state;
      pllClkEn        <= nxRun;
      macEn           <= nxRun;
      hostIfEn        <= nxRun;
      phyRxEnergyOnly <= nxSleep;
      edLowPower      <= nxSleep;
      internalReset   <= pdWake;
    end
  end

  // Global registers; a wake from soft power-down restores defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerMode   <= spmc_pkg::POWER_MODE_RST;
      idleTimeout <= spmc_pkg::IDLE_TIMEOUT_RST;
      lpiReq      <= 1'b0;
    end else if (pdWake) begin
      powerMode   <= spmc_pkg::POWER_MODE_RST;
      idleTimeout <= spmc_pkg::IDLE_TIMEOUT_RST;
      lpiReq      <= 1'b0;
    end else if (wrEn) begin
      if (modeWr) powerMode <= wrMode;
      if (addr == spmc_pkg::REG_IDLE_TIMEOUT) idleTimeout <= wrData;
      if (addr == spmc_pkg::REG_EEE_CTRL) lpiReq <= wrData[spmc_pkg::EEE_LPI];
    end
  end

  // Per-port power-down bits and their read-back
  logic [NPORT-1:0] portCtrlHit;
  logic [NPORT-1:0] phyCtrlHit;
  for (genvar p = 0; p < NPORT; p++) begin : gPort
    assign portCtrlHit[p] = portHit(addr, spmc_pkg::REG_PORT_CTRL, p);
    assign phyCtrlHit[p]  = portHit(addr, spmc_pkg::REG_PHY_CTRL_HI, p);
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        portPd[p] <= 1'b0;
        phyPd[p]  <= 1'b0;
      end else if (pdWake) begin
        portPd[p] <= 1'b0;
        phyPd[p]  <= 1'b0;
      end else if (wrEn) begin
        if (portCtrlHit[p]) portPd[p] <= wrData[spmc_pkg::PORT_PD];
        if (phyCtrlHit[p]) phyPd[p] <= wrData[spmc_pkg::PHY_PD];
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        phyPowerDown[p] <= 1'b0;
      end else begin
        phyPowerDown[p] <= nxPd || portPd[p] || phyPd[p];
      end
    end
  end

  // Idle timer; tick unit is a parameter because the interval unit is unspecified
  wire idleRun = inEdAwake && !cableEnergy;
  spmc_tick_div #(.DIV(SLEEP_TICK_CYC)) uSleepTick (
    .clk  (clk),
    .nrst (nrst),
    .clr  (!idleRun),
    .tick (sleepTick)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idleCnt <= 9'h000;
    end else if (!idleRun) begin
      idleCnt <= 9'h000;
    end else if (sleepTick && idleCnt != 9'h1FF) begin
      idleCnt <= idleCnt + 1'b1;
    end
  end

  // Keep-alive pulse while asleep; the first one comes a full period after entry
  spmc_tick_div #(.DIV(PULSE_PERIOD_CYC)) uPulseTick (
    .clk  (clk),
    .nrst (nrst),
    .clr  (!inSleep),
    .tick (periodTick)
  );
  wire [3:0] next_pulseCnt = !inSleep ? 4'h0 :
                             periodTick ? 4'(PW_CYC) :
                             (pulseCnt != 4'h0) ? pulseCnt - 1'b1 : 4'h0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulseCnt  <= 4'h0;
      linkPulse <= 1'b0;
      pulseRun  <= 4'h0;
    end else begin
      pulseCnt  <= next_pulseCnt;
      linkPulse <= (next_pulseCnt != 4'h0);
      pulseRun  <= linkPulse ? pulseRun + 1'b1 : 4'h0; // Run length for the width check
    end
  end

  // Transmit LPI: enter only between frames, leave with a wake delay
  wire lpiEnter = lpiReq && !lpiActive && !macTxBusy && nxRun;
  wire lpiLeave = lpiActive && (!lpiReq || !nxRun);
  wire next_lpiActive = lpiEnter || (lpiActive && !lpiLeave);
  wire [WKW-1:0] next_wakeCnt = lpiLeave ? WKW'(WK_CYC) :
                                (wakeCnt != '0) ? wakeCnt - 1'b1 : '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lpiActive   <= 1'b0;
      wakeCnt     <= '0;
      txLpiAssert <= 1'b0;
      macTxAllow  <= 1'b1;
    end else begin
      lpiActive   <= next_lpiActive;
      wakeCnt     <= next_wakeCnt;
      txLpiAssert <= next_lpiActive;
      macTxAllow  <= nxRun && !next_lpiActive && (next_wakeCnt == '0);
    end
  end

  // Clock gating per direction; the switch core stops only when both rest
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      macTxClkEn  <= 1'b1;
      macRxClkEn  <= 1'b1;
      switchClkEn <= 1'b1;
    end else begin
      macTxClkEn  <= macEn && !txLpiAssert;
      macRxClkEn  <= macEn && !rxLpiInd;
      switchClkEn <= macEn && !(txLpiAssert && rxLpiInd);
    end
  end

  spmc_buf_pool #(.NBUF(NBUF)) uBufPool (
    .clk        (clk),
    .nrst       (nrst),
    .clr        (pdWake),
    .allocReq   (bufAllocReq && macEn),
    .freeReq    (bufFreeReq),
    .allocGrant (bufAllocGrant),
    .freeCount  (freeCount)
  );

  // Read mux; unmapped addresses read as zero
  wire [15:0] freeWide = 16'(freeCount);
  wire [7:0] statusByte = {3'h0, cableEnergy, macTxAllow, rxLpiInd, txLpiAssert, inEdAwake};
  wire [7:0] portByte   = {4'h0, |(portCtrlHit & portPd), 3'h0};
  wire [7:0] phyByte    = {4'h0, |(phyCtrlHit & phyPd), 3'h0};
  wire [7:0] rdMux =
    (addr == spmc_pkg::REG_POWER_MODE)   ? {3'h0, powerMode, 3'h0} :
    (addr == spmc_pkg::REG_IDLE_TIMEOUT) ? idleTimeout :
    (addr == spmc_pkg::REG_EEE_CTRL)     ? {7'h00, lpiReq} :
    (addr == spmc_pkg::REG_STATUS)       ? statusByte :
    (addr == spmc_pkg::REG_FREE_LO)      ? freeWide[7:0] :
    (addr == spmc_pkg::REG_FREE_HI)      ? freeWide[15:8] :
    (|portCtrlHit)                       ? portByte :
    (|phyCtrlHit)                        ? phyByte : 8'h00;

  // Read data stand for one cycle only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= rdEn ? rdMux : 8'h00;
    end
  end
  chk_mode_reserved: assert property (@(posedge clk) disable iff (!nrst)
    (wrEn && modeHit && wrMode == spmc_pkg::MODE_RSVD) |=> $stable(powerMode))
    else $error("reserved mode code was stored");
  chk_wake_defaults: assert property (@(posedge clk) disable iff (!nrst)
    internalReset |-> powerMode == spmc_pkg::MODE_NORMAL && !lpiReq && portPd == '0)
    else $error("registers not at defaults after wake");
  chk_normal_on: assert property (@(posedge clk) disable iff (!nrst)
    (state == spmc_pkg::ST_NORMAL) |-> pllClkEn && macEn && hostIfEn && !phyRxEnergyOnly)
    else $error("normal mode with a block gated");
  chk_sleep_entry: assert property (@(posedge clk) disable iff (!nrst)
    (inEdAwake && powerMode == spmc_pkg::MODE_ENERGY && !cableEnergy && sleepExpire)
      |=> inSleep && edLowPower)
    else $error("idle timeout did not enter sleep");
  chk_sleep_gating: assert property (@(posedge clk) disable iff (!nrst)
    inSleep |-> !pllClkEn && !macEn && !hostIfEn && phyRxEnergyOnly)
    else $error("sleep left circuitry running");
  chk_energy_wake: assert property (@(posedge clk) disable iff (!nrst)
    (inSleep && cableEnergy) |=> inEdAwake ##1 (pllClkEn || !inEdAwake))
    else $error("energy did not wake the device");
  chk_pulse_width: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(linkPulse) && inSleep) |-> pulseRun == 4'(PW_CYC))
    else $error("keep-alive pulse width wrong");
  chk_softpd_off: assert property (@(posedge clk) disable iff (!nrst)
    (state == spmc_pkg::ST_SOFT_PD) |-> !pllClkEn && !macEn ##1 (&phyPowerDown || $past(pdWake)))
    else $error("soft power-down left PHY or MAC on");
  chk_softpd_wake: assert property (@(posedge clk) disable iff (!nrst)
    pdWake |=> state == spmc_pkg::ST_NORMAL && internalReset && pllClkEn)
    else $error("host access did not wake soft power-down");
  chk_port_down: assert property (@(posedge clk) disable iff (!nrst)
    (portPd[0] || phyPd[0]) |=> phyPowerDown[0])
    else $error("port power-down bit ignored");
  chk_tx_clock: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (macTxClkEn == ($past(macEn) && !$past(txLpiAssert)))
      && (macRxClkEn == ($past(macEn) && !$past(rxLpiInd))))
    else $error("direction clock gating wrong");
  chk_lpi_boundary: assert property (@(posedge clk) disable iff (!nrst)
    $rose(txLpiAssert) |-> !$past(macTxBusy))
    else $error("LPI entered mid-frame");
  chk_idle_restart: assert property (@(posedge clk) disable iff (!nrst)
    cableEnergy |=> idleCnt == 9'h000)
    else $error("idle timer not restarted by energy");
  chk_lpi_block: assert property (@(posedge clk) disable iff (!nrst)
    txLpiAssert |-> !macTxAllow)
    else $error("transmit allowed during LPI");
  chk_lpi_resume: assert property (@(posedge clk) disable iff (!nrst)
    $fell(txLpiAssert) |-> !macTxAllow[*8])
    else $error("transmit resumed without wake delay");
endmodule

// ---- tb/spmc_host_model.sv ----
// Host CPU model driving the register port of the power control block
`timescale 1ns/1ns
module spmc_host_model (
  input  wire logic       clk,    // System clock
  output logic      [7:0] addr,   // Register address
  output logic      [7:0] wrData, // Write data
  output logic            wrStb,  // Write strobe
  output logic            rdStb,  // Read strobe
  input  wire logic [7:0] rdData  // Read data
);
  // Quiet bus at time zero
  initial begin
    addr = 8'h00;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
  end
  // One-cycle write; released lines inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    addr <= ~a;
    wrData <= ~d;
  endtask
  // One-cycle read, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    addr <= ~a;
    #1 d = rdData;
  endtask
endmodule

// ---- tb/switch_power_mode_control_bench.sv ----
// Self-checking bench for the power mode control block
`timescale 1ns/1ns
module switch_power_mode_control_bench;
  logic clk, nrst, cableEnergy, macTxBusy, rxLpiInd, bufAllocReq, bufFreeReq;
  logic [7:0] addr, wrData, rdData, d;
  logic wrStb, rdStb, bufAllocGrant, pllClkEn, macEn, hostIfEn, phyRxEnergyOnly;
  logic [2:0] phyPowerDown;
  logic edLowPower, linkPulse, txLpiAssert, macTxAllow, macTxClkEn, macRxClkEn;
  logic switchClkEn, internalReset;
  int nFail, numChecks, n;
  // Rows: address, write data, expected read, expected port power-down
  logic [31:0] rows [6] = '{32'h1D080801, 32'h2D080803, 32'hB0080807, 32'h1D000006,
                            32'h075A0006, 32'h0F030306};
  spmc_host_model u_spmc_host_model (.clk, .addr, .wrData, .wrStb, .rdStb, .rdData);
  spmc_power_ctrl #(.SLEEP_TICK_CYC(4), .PULSE_PERIOD_CYC(40)) u_spmc_power_ctrl (
    .clk, .nrst, .addr, .wrData, .wrStb, .rdStb, .rdData, .cableEnergy, .macTxBusy,
    .rxLpiInd, .bufAllocReq, .bufFreeReq, .bufAllocGrant, .pllClkEn, .macEn,
    .hostIfEn, .phyRxEnergyOnly, .phyPowerDown, .edLowPower, .linkPulse, .txLpiAssert,
    .macTxAllow, .macTxClkEn, .macRxClkEn, .switchClkEn, .internalReset);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far beyond the longest wait of the run
  initial begin
    #200000;
    nFail++;
    testDone();
  end
  initial begin
    {nrst, cableEnergy, macTxBusy, rxLpiInd, bufAllocReq, bufFreeReq} = 6'h00;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1 check({pllClkEn, macEn, hostIfEn, edLowPower}, 16'h000E);
    u_spmc_host_model.rd(8'h0E, d);
    check(d, 16'h0000);
    // Register rows
    foreach (rows[i]) begin
      u_spmc_host_model.wr(rows[i][31:24], rows[i][23:16]);
      u_spmc_host_model.rd(rows[i][31:24], d);
      check(d, rows[i][15:8]);
      check(phyPowerDown, rows[i][2:0]);
    end
    // Energy detect: idle timer restarts on energy, sleeps after timeout
    u_spmc_host_model.wr(8'h0E, 8'h08);
    u_spmc_host_model.rd(8'h0E, d);
    check(d, 16'h0008);
    repeat (8) @(posedge clk);
    cableEnergy <= 1'b1;
    @(posedge clk) cableEnergy <= 1'b0;
    for (n = 0; n < 60 && edLowPower !== 1'b1; n++) @(posedge clk);
    check(n >= 15 && n <= 22, 16'h0001);
    #1 check({pllClkEn, macEn, hostIfEn, phyRxEnergyOnly}, 16'h0001);
    u_spmc_host_model.rd(8'h0F, d);
    check(d, 16'h0000);
    for (n = 0; n < 60 && linkPulse !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 30 && linkPulse === 1'b1; n++) @(posedge clk);
    check(n, spmc_pkg::PULSE_WIDTH_CYC);
    @(posedge clk) cableEnergy <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check({edLowPower, pllClkEn, macEn}, 16'h0003);
    // Reserved code leaves normal mode in place
    u_spmc_host_model.wr(8'h0E, 8'h00);
    u_spmc_host_model.wr(8'h0E, 8'h18);
    u_spmc_host_model.rd(8'h0E, d);
    check(d, 16'h0000);
    // Soft power-down, then a wake access resets registers
    u_spmc_host_model.wr(8'h0E, 8'h10);
    @(posedge clk);
    #1 check({pllClkEn, macEn, phyPowerDown}, 16'h0007);
    u_spmc_host_model.rd(8'h0F, d);
    n = internalReset;
    repeat (3) begin
      @(posedge clk);
      #1 n += internalReset;
    end
    check(n, 16'h0001);
    u_spmc_host_model.rd(8'h0F, d);
    check(d, spmc_pkg::IDLE_TIMEOUT_RST);
    // Shared frame memory accounting
    @(posedge clk) bufAllocReq <= 1'b1;
    n = 0;
    repeat (3) @(posedge clk) n += bufAllocGrant;
    bufAllocReq <= 1'b0;
    @(posedge clk) n += bufAllocGrant;
    check(n, 16'h0003);
    u_spmc_host_model.rd(8'h61, d);
    check(d, 16'h00FD);
    @(posedge clk) bufFreeReq <= 1'b1;
    @(posedge clk) bufFreeReq <= 1'b0;
    u_spmc_host_model.rd(8'h62, d);
    check(d, 16'h0001);
    u_spmc_host_model.rd(8'h61, d);
    check(d, 16'h00FE);
    // Transmit LPI waits for frame end, receive LPI independent
    macTxBusy <= 1'b1;
    u_spmc_host_model.wr(8'h50, 8'h01);
    repeat (3) @(posedge clk);
    #1 check(txLpiAssert, 16'h0000);
    @(posedge clk) macTxBusy <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({txLpiAssert, macTxAllow, macRxClkEn}, 16'h0005);
    @(posedge clk) rxLpiInd <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({macTxClkEn, macRxClkEn, switchClkEn}, 16'h0000);
    rxLpiInd <= 1'b0;
    u_spmc_host_model.wr(8'h50, 8'h00);
    for (n = 0; n < 4000 && macTxAllow !== 1'b1; n++) @(posedge clk);
    check(n >= 2995 && n <= 3005, 16'h0001);
    testDone();
  end
endmodule
